// file: pkg/fcsd_consts.vh
// constants for the flash command host controller
`ifndef FCSD_CONSTS_VH
`define FCSD_CONSTS_VH

// ==========================================================
// register map (byte offsets on the axi4-lite bus)
`define FCSD_REG_CTRL    8'h00
`define FCSD_REG_ADDR    8'h04
`define FCSD_REG_DATA1   8'h08
`define FCSD_REG_DATA2   8'h0c
`define FCSD_REG_STATUS  8'h10
`define FCSD_REG_RDATA   8'h14

// ==========================================================
// control register fields
`define FCSD_CTL_CODE    7:0
`define FCSD_CTL_WR2     8
`define FCSD_CTL_WR3     9
`define FCSD_CTL_RD      10
`define FCSD_CTL_BYTE    11
`define FCSD_CTL_NOCMD   12
`define FCSD_CTL_WAIT    13
`define FCSD_CTL_W       14
`define FCSD_CTL_RESET   14'h0000
`define FCSD_CTL_INIT    14'h2197

// ==========================================================
// command codes
`define FCSD_OP_READ     8'hff
`define FCSD_OP_IDENT    8'h90
`define FCSD_OP_CSR      8'h70
`define FCSD_OP_XSR      8'h71
`define FCSD_OP_CLEAR    8'h50
`define FCSD_OP_PBREAD   8'h75
`define FCSD_OP_SEQLOAD  8'he0
`define FCSD_OP_FLUSH    8'h0c
`define FCSD_OP_CONFIRM  8'hd0

// ==========================================================
// compatible status layout
`define FCSD_CSR_MASK    8'hf8
`define FCSD_CSR_ERASE   5
`define FCSD_CSR_PROG    4

// ==========================================================
// bus timing
`define FCSD_CLK_NS      25
`define FCSD_SETUP_NS    25
`define FCSD_WE_NS       50
`define FCSD_ACC_NS      70
`define FCSD_BUSY_NS     100
`define FCSD_SYNC_LAT    4
`define FCSD_CYC(ns)     (((ns) + `FCSD_CLK_NS - 1) / `FCSD_CLK_NS)

`define FCSD_RESP_OK     2'b00
`define FCSD_RESP_ERR    2'b10

`endif

// file: hdl/fcsd_sync.v
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module fcsd_sync #(
    parameter W = 1
) (
    input  wire         clk,
    input  wire         resetn,
    input  wire [W-1:0] din,
    output reg  [W-1:0] dout_q
);
    reg [W-1:0] s1_q;
    reg [W-1:0] s2_q;
    reg [W-1:0] s3_q;

    // ==========================================================
    // stage one feeds stage two only
    always @(posedge clk) begin
        if (!resetn) begin
            s1_q   <= {W{1'b0}};
            s2_q   <= {W{1'b0}};
            s3_q   <= {W{1'b0}};
            dout_q <= {W{1'b0}};
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                dout_q <= s3_q;
            end
        end
    end
endmodule // fcsd_sync

// file: hdl/fcsd_host.v
// flash command host: axi4-lite orders in, flash bus cycles out
`timescale 1ns/1ps
`include "fcsd_consts.vh"
module fcsd_host (
    input  wire        clk,
    input  wire        resetn,
    input  wire [7:0]  s_awaddr,
    input  wire        s_awvalid,
    output reg         s_awready,
    input  wire [31:0] s_wdata,
    input  wire [3:0]  s_wstrb,
    input  wire        s_wvalid,
    output reg         s_wready,
    output reg  [1:0]  s_bresp,
    output reg         s_bvalid,
    input  wire        s_bready,
    input  wire [7:0]  s_araddr,
    input  wire        s_arvalid,
    output reg         s_arready,
    output reg  [31:0] s_rdata,
    output reg  [1:0]  s_rresp,
    output reg         s_rvalid,
    input  wire        s_rready,
    output reg  [20:0] flash_addr,
    output reg  [15:0] flash_dq_o,
    output reg         flash_dq_oe,
    input  wire [15:0] flash_dq_i,
    output reg         chip_select_0_n,
    output reg         chip_select_1_n,
    output reg         flash_oe_n,
    output reg         flash_we_n,
    output reg         flash_byte_n,
    input  wire        ready_busy_out
);
    // ==========================================================
    // engine states and timing counts
    localparam [2:0] ST_IDLE   = 3'd0;
    localparam [2:0] ST_SETUP  = 3'd1;
    localparam [2:0] ST_STROBE = 3'd2;
    localparam [2:0] ST_HOLD   = 3'd3;
    localparam [2:0] ST_READ   = 3'd4;
    localparam [2:0] ST_GAP    = 3'd5;
    localparam [2:0] ST_RBWAIT = 3'd6;
    localparam [7:0] SETUP_CYC = `FCSD_CYC(`FCSD_SETUP_NS);
    localparam [7:0] WE_CYC    = `FCSD_CYC(`FCSD_WE_NS);
    localparam [7:0] RD_CYC    = `FCSD_CYC(`FCSD_ACC_NS) + `FCSD_SYNC_LAT;
    localparam [7:0] BUSY_CYC  = `FCSD_CYC(`FCSD_BUSY_NS);

    reg  [`FCSD_CTL_W-1:0] ctrl_q;
    reg  [20:0]            addr_q;
    reg  [15:0]            data1_q;
    reg  [15:0]            data2_q;
    reg  [7:0]             waddr_q;
    reg  [31:0]            wdata_q;
    reg  [3:0]             wstrb_q;
    reg                    start_q;
    reg  [2:0]             st_q;
    reg  [1:0]             ph_q;
    reg  [7:0]             cnt_q;
    reg  [`FCSD_CTL_W-1:0] op_q;
    reg                    init_q;
    reg                    init_run_q;
    reg                    done_q;
    reg  [15:0]            rdata_q;
    reg                    bad_seq_q;
    wire [15:0]            dq_sync;
    wire                   rb_sync;
    wire [7:0]             code;
    wire                   cnt_cmd;
    wire                   hi_first;
    wire                   csr_read;
    reg  [31:0]            wold;
    wire [31:0]            wmerge;
    reg  [2:0]             nxt;
    reg  [15:0]            cyc_data;
    reg  [20:0]            cyc_addr;

    // ==========================================================
    // pin synchronisers
    fcsd_sync #(.W(16)) u_dq_sync (
        .clk    (clk),
        .resetn (resetn),
        .din    (flash_dq_i),
        .dout_q (dq_sync)
    );

    fcsd_sync #(.W(1)) u_rb_sync (
        .clk    (clk),
        .resetn (resetn),
        .din    (ready_busy_out),
        .dout_q (rb_sync)
    );

    // ==========================================================
    // phase sequencing: 0 command, 1 second write, 2 third, 3 read
    function [2:0] next_ph;
        input [1:0]             p;
        input [`FCSD_CTL_W-1:0] c;
        begin
            next_ph = 3'b100;
            if (p == 2'd0 && c[`FCSD_CTL_WR2]) begin
                next_ph = 3'd1;
            end else if (p == 2'd1 && c[`FCSD_CTL_WR3]) begin
                next_ph = 3'd2;
            end else if (p != 2'd3 && c[`FCSD_CTL_RD]) begin
                next_ph = 3'd3;
            end
        end
    endfunction

    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0]  strb;
        integer      i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    merge[i*8 +: 8] = nw[i*8 +: 8];
                end
            end
        end
    endfunction

    assign code     = op_q[`FCSD_CTL_CODE];
    // load and flush carry counts: low byte only, high count forced 0
    assign cnt_cmd  = (code == `FCSD_OP_SEQLOAD) || (code == `FCSD_OP_FLUSH);
    assign hi_first = (code == `FCSD_OP_FLUSH) && op_q[`FCSD_CTL_BYTE]
                      && addr_q[0];
    // array, identifier, buffer and extended reads are not masked
    assign csr_read = (code != `FCSD_OP_READ) && (code != `FCSD_OP_IDENT)
                      && (code != `FCSD_OP_PBREAD) && (code != `FCSD_OP_XSR);

    // byte-lane merge of the addressed register, cut to width on store
    always @* begin
        case (waddr_q)
            `FCSD_REG_CTRL:  wold = {18'h0, ctrl_q};
            `FCSD_REG_ADDR:  wold = {11'h0, addr_q};
            `FCSD_REG_DATA1: wold = {16'h0, data1_q};
            `FCSD_REG_DATA2: wold = {16'h0, data2_q};
            default:         wold = 32'h0000_0000;
        endcase
    end
    assign wmerge = merge(wold, wdata_q, wstrb_q);

    always @* begin
        nxt      = next_ph(ph_q, op_q);
        cyc_addr = addr_q;
        cyc_data = {8'h00, code};
        case (ph_q)
            2'd1: begin
                if (init_run_q) begin
                    cyc_data = {8'h00, `FCSD_OP_CONFIRM};
                end else if (cnt_cmd) begin
                    cyc_data = hi_first ? 16'h0000
                                        : {8'h00, data1_q[7:0]};
                end else begin
                    cyc_data = data1_q;
                end
            end
            2'd2: begin
                if (cnt_cmd) begin
                    cyc_data = hi_first ? {8'h00, data1_q[7:0]}
                                        : 16'h0000;
                end else begin
                    cyc_data = data2_q;
                end
            end
            default: begin
                cyc_data = {8'h00, code};
            end
        endcase
    end

    // ==========================================================
    // axi4-lite slave
    always @(posedge clk) begin
        if (!resetn) begin
            s_awready <= 1'b1;
            s_wready  <= 1'b1;
            s_bvalid  <= 1'b0;
            s_bresp   <= `FCSD_RESP_OK;
            s_arready <= 1'b1;
            s_rvalid  <= 1'b0;
            s_rresp   <= `FCSD_RESP_OK;
            s_rdata   <= 32'h0000_0000;
            waddr_q   <= 8'h00;
            wdata_q   <= 32'h0000_0000;
            wstrb_q   <= 4'h0;
            ctrl_q    <= `FCSD_CTL_RESET;
            addr_q    <= 21'h00_0000;
            data1_q   <= 16'h0000;
            data2_q   <= 16'h0000;
            start_q   <= 1'b0;
        end else begin
            start_q <= 1'b0;
            if (s_awvalid && s_awready) begin
                s_awready <= 1'b0;
                waddr_q   <= s_awaddr;
            end
            if (s_wvalid && s_wready) begin
                s_wready <= 1'b0;
                wdata_q  <= s_wdata;
                wstrb_q  <= s_wstrb;
            end
            if (!s_awready && !s_wready && !s_bvalid) begin
                s_bvalid <= 1'b1;
                s_bresp  <= `FCSD_RESP_OK;
                case (waddr_q)
                    `FCSD_REG_CTRL: begin
                        // writes during a running sequence are dropped
                        if (st_q == ST_IDLE && !init_q) begin
                            ctrl_q  <= wmerge[`FCSD_CTL_W-1:0];
                            start_q <= 1'b1;
                        end
                    end
                    `FCSD_REG_ADDR: begin
                        addr_q <= wmerge[20:0];
                    end
                    `FCSD_REG_DATA1: begin
                        data1_q <= wmerge[15:0];
                    end
                    `FCSD_REG_DATA2: begin
                        data2_q <= wmerge[15:0];
                    end
                    `FCSD_REG_STATUS, `FCSD_REG_RDATA: begin
                    end
                    default: begin
                        s_bresp <= `FCSD_RESP_ERR;
                    end
                endcase
            end
            if (s_bvalid && s_bready) begin
                s_bvalid  <= 1'b0;
                s_awready <= 1'b1;
                s_wready  <= 1'b1;
            end
            if (s_arvalid && s_arready) begin
                s_arready <= 1'b0;
                s_rvalid  <= 1'b1;
                s_rresp   <= `FCSD_RESP_OK;
                case (s_araddr)
                    `FCSD_REG_CTRL:   s_rdata <= {18'h0, ctrl_q};
                    `FCSD_REG_ADDR:   s_rdata <= {11'h0, addr_q};
                    `FCSD_REG_DATA1:  s_rdata <= {16'h0, data1_q};
                    `FCSD_REG_DATA2:  s_rdata <= {16'h0, data2_q};
                    `FCSD_REG_STATUS: s_rdata <= {27'h0, done_q, rb_sync,
                                                  bad_seq_q, ~init_q,
                                                  (st_q != ST_IDLE)};
                    `FCSD_REG_RDATA:  s_rdata <= {16'h0, rdata_q};
                    default: begin
                        s_rdata <= 32'h0000_0000;
                        s_rresp <= `FCSD_RESP_ERR;
                    end
                endcase
            end
            if (s_rvalid && s_rready) begin
                s_rvalid  <= 1'b0;
                s_arready <= 1'b1;
            end
        end
    end

    // ==========================================================
    // flash bus cycle engine
    always @(posedge clk) begin
        if (!resetn) begin
            st_q            <= ST_IDLE;
            ph_q            <= 2'd0;
            cnt_q           <= 8'h00;
            op_q            <= `FCSD_CTL_RESET;
            init_q          <= 1'b1;
            init_run_q      <= 1'b0;
            done_q          <= 1'b0;
            rdata_q         <= 16'h0000;
            bad_seq_q       <= 1'b0;
            flash_addr      <= 21'h00_0000;
            flash_dq_o      <= 16'h0000;
            flash_dq_oe     <= 1'b0;
            chip_select_0_n <= 1'b1;
            chip_select_1_n <= 1'b1;
            flash_oe_n      <= 1'b1;
            flash_we_n      <= 1'b1;
            flash_byte_n    <= 1'b1;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    cnt_q <= 8'h00;
                    if (init_q) begin
                        // lock bits read locked until uploaded
                        op_q       <= `FCSD_CTL_INIT;
                        init_run_q <= 1'b1;
                        ph_q       <= 2'd0;
                        st_q       <= ST_SETUP;
                    end else if (start_q) begin
                        op_q   <= ctrl_q;
                        done_q <= 1'b0;
                        flash_byte_n <= ~ctrl_q[`FCSD_CTL_BYTE];
                        if (!ctrl_q[`FCSD_CTL_NOCMD]) begin
                            ph_q <= 2'd0;
                            st_q <= ST_SETUP;
                        end else begin
                            // raw cycles for buffer pairs and reads
                            ph_q <= 2'd1;
                            st_q <= ST_SETUP;
                        end
                    end
                end
                ST_SETUP: begin
                    chip_select_0_n <= 1'b0;
                    chip_select_1_n <= 1'b0;
                    flash_addr      <= cyc_addr;
                    if (ph_q == 2'd3) begin
                        flash_oe_n <= 1'b0;
                        cnt_q      <= 8'h00;
                        st_q       <= ST_READ;
                    end else begin
                        flash_dq_o  <= cyc_data;
                        flash_dq_oe <= 1'b1;
                        cnt_q       <= cnt_q + 8'h01;
                        if (cnt_q + 8'h01 >= SETUP_CYC) begin
                            cnt_q <= 8'h00;
                            st_q  <= ST_STROBE;
                        end
                    end
                end
                ST_STROBE: begin
                    flash_we_n <= 1'b0;
                    cnt_q      <= cnt_q + 8'h01;
                    if (cnt_q + 8'h01 >= WE_CYC) begin
                        st_q <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    // rising strobe latches code and address
                    flash_we_n <= 1'b1;
                    cnt_q      <= 8'h00;
                    st_q       <= ST_GAP;
                end
                ST_READ: begin
                    cnt_q <= cnt_q + 8'h01;
                    if (cnt_q + 8'h01 >= RD_CYC) begin
                        if (csr_read) begin
                            rdata_q <= dq_sync
                                       & {8'h00, `FCSD_CSR_MASK};
                            bad_seq_q <= dq_sync[`FCSD_CSR_ERASE]
                                       & dq_sync[`FCSD_CSR_PROG];
                        end else begin
                            rdata_q <= dq_sync;
                        end
                        flash_oe_n <= 1'b1;
                        cnt_q      <= 8'h00;
                        st_q       <= ST_GAP;
                    end
                end
                ST_GAP: begin
                    // chip deselected between cycles and before the busy wait
                    chip_select_0_n <= 1'b1;
                    chip_select_1_n <= 1'b1;
                    flash_dq_oe     <= 1'b0;
                    cnt_q           <= 8'h00;
                    if (!nxt[2] && (nxt[1:0] != 2'd3 ||
                                    !op_q[`FCSD_CTL_WAIT] ||
                                    ph_q == 2'd3)) begin
                        ph_q <= nxt[1:0];
                        st_q <= ST_SETUP;
                    end else if (op_q[`FCSD_CTL_WAIT] && ph_q != 2'd3) begin
                        st_q <= ST_RBWAIT;
                    end else begin
                        done_q     <= 1'b1;
                        init_q     <= 1'b0;
                        init_run_q <= 1'b0;
                        st_q       <= ST_IDLE;
                    end
                end
                ST_RBWAIT: begin
                    // pin may fall late; ignore it for the busy delay
                    if (cnt_q < BUSY_CYC) begin
                        cnt_q <= cnt_q + 8'h01;
                    end else if (rb_sync) begin
                        cnt_q <= 8'h00;
                        if (!nxt[2]) begin
                            ph_q <= nxt[1:0];
                            st_q <= ST_SETUP;
                        end else begin
                            done_q     <= 1'b1;
                            init_q     <= 1'b0;
                            init_run_q <= 1'b0;
                            st_q       <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end
endmodule // fcsd_host

// file: bench/fcsd_checker.sv
// port assertions for the flash command host
`timescale 1ns/1ps
module fcsd_checker (
    input wire        clk,
    input wire        resetn,
    input wire        s_bvalid,
    input wire        s_bready,
    input wire [20:0] flash_addr,
    input wire        flash_dq_oe,
    input wire        chip_select_0_n,
    input wire        chip_select_1_n,
    input wire        flash_oe_n,
    input wire        flash_we_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // ====
    // flash bus framing
    AST_CS_TOGETHER: assert property (
        chip_select_0_n == chip_select_1_n) else $error("selects differ");
    AST_WE_IN_CS: assert property (
        !flash_we_n |-> !chip_select_0_n && flash_oe_n && flash_dq_oe)
        else $error("strobe outside a driven select");
    AST_WE_WIDTH: assert property (
        $fell(flash_we_n) |=> !flash_we_n ##1 flash_we_n)
        else $error("strobe width wrong");
    AST_WE_CS_HOLD: assert property (
        $rose(flash_we_n) |-> !chip_select_0_n ##1 chip_select_0_n)
        else $error("select not held after strobe");
    AST_ADDR_STABLE: assert property (
        !chip_select_0_n && $past(!chip_select_0_n) |-> $stable(flash_addr))
        else $error("address moved inside a cycle");
    AST_SETUP: assert property (
        $fell(chip_select_0_n) && flash_dq_oe |-> flash_we_n ##1 !flash_we_n)
        else $error("write setup cycle missing");
    AST_READ_NO_DRIVE: assert property (
        !flash_oe_n |-> !flash_dq_oe && !chip_select_0_n)
        else $error("host drives data during read");
    AST_OE_ACCESS: assert property (
        $fell(flash_oe_n) |-> !flash_oe_n [*5])
        else $error("read enable shorter than access");
    cover property (!flash_we_n);
    cover property ($fell(flash_oe_n));
    cover property (s_bvalid && s_bready);
endmodule // fcsd_checker

bind fcsd_host fcsd_checker u_chk (
    .clk(clk), .resetn(resetn), .s_bvalid(s_bvalid), .s_bready(s_bready),
    .flash_addr(flash_addr), .flash_dq_oe(flash_dq_oe),
    .chip_select_0_n(chip_select_0_n), .chip_select_1_n(chip_select_1_n),
    .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n));

// file: bench/fcsd_flash_model.sv
// behavioural flash device facing the host controller
`timescale 1ns/1ps
module fcsd_flash_model #(
    parameter MAKER_ID = 16'h00c3, // arbitrary value
    parameter PART_ID  = 16'h5a3c  // arbitrary value
) (
    input  wire [20:0] addr,
    input  wire [15:0] dq_o,
    input  wire        cs0_n,
    input  wire        cs1_n,
    input  wire        oe_n,
    input  wire        we_n,
    input  wire        byte_n,
    input  wire        fail_en,
    output wire [15:0] dq_i,
    output wire        rb
);
    reg [1:0]  mode_q = 2'd0;
    reg [7:0]  pend_q = 8'h00;
    reg        busy_q = 1'b0;
    reg        susp_q = 1'b0;
    reg        bsel_q = 1'b0;
    reg [2:0]  err_q  = 3'b000;
    reg [15:0] rd;
    // ====
    // read path; status reserved bits 2 and 0 set so the host must mask them
    always @* begin
        case (mode_q)
        2'd1: rd = (byte_n ? addr[1] : addr[0]) ? PART_ID : MAKER_ID;
        2'd2: rd = {8'h00, !busy_q, susp_q, err_q, 3'b101};
        2'd3: rd = addr[15:0] ^ {bsel_q, 15'h0aaa};
        default: rd = addr[15:0] ^ 16'h5555;
        endcase
    end
    // a released bus shows the inverse, never the last value
    assign dq_i = (!cs0_n && !cs1_n && !oe_n) ? rd : ~rd;
    assign rb   = !busy_q;
    // ====
    // command decoder
    always @(posedge we_n) begin
        if (!cs0_n && !cs1_n && pend_q != 8'h00) begin
            mode_q = 2'd2;
            if (pend_q == 8'h40 || pend_q == 8'h10) err_q[1] |= fail_en;
            if (pend_q == 8'h20) err_q[2] |= fail_en;
            if (pend_q == 8'hb0 && busy_q) begin
                susp_q = 1'b1;
                busy_q = 1'b0;
            end else begin
                susp_q = 1'b0;
                busy_q = 1'b1;
                // long enough for a suspend to land
                busy_q <= #2000 1'b0;
            end
            pend_q = 8'h00;
        end else if (!cs0_n && !cs1_n) begin
            case (dq_o[7:0])
            8'hff: mode_q = 2'd0;
            8'h90: mode_q = 2'd1;
            8'h70: mode_q = 2'd2;
            8'h50: err_q = 3'b000;
            8'h71, 8'h75: mode_q = 2'd3;
            8'h72: bsel_q = !bsel_q;
            8'h40, 8'h10, 8'h20, 8'hb0, 8'h97: pend_q = dq_o[7:0];
            default: ;
            endcase
        end
    end
endmodule // fcsd_flash_model

// file: bench/testbench.sv
// self-checking bench for the flash command host
`timescale 1ns/1ps
`include "fcsd_consts.vh"
module testbench;
    localparam [15:0] MID = 16'h00c3; // arbitrary value
    localparam [15:0] PID = 16'h5a3c; // arbitrary value
    localparam [13:0] F2 = 14'h0100, FR = 14'h0400, FB = 14'h0800;
    localparam [13:0] FW = 14'h2000;
    reg         clk = 1'b0, resetn = 1'b0, fail_en = 1'b0;
    reg  [7:0]  s_awaddr = 8'h00, s_araddr = 8'h00;
    reg  [31:0] s_wdata = 32'h0, r;
    reg         s_awvalid = 1'b0, s_wvalid = 1'b0, s_arvalid = 1'b0;
    // ready held high: legal, and saves a turnaround per access
    reg         s_bready = 1'b1, s_rready = 1'b1;
    reg  [1:0]  rs, bs;
    wire        s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
    wire [1:0]  s_bresp, s_rresp;
    wire [31:0] s_rdata;
    wire [20:0] f_addr;
    wire [15:0] dq_o, dq_i;
    wire        dq_oe, cs0_n, cs1_n, oe_n, we_n, byte_n, rb;
    integer     fails = 0, n_tests = 0, cycles = 0;
    always #12.5 clk = ~clk;
    fcsd_host u_dut (.clk(clk), .resetn(resetn), .s_awaddr(s_awaddr),
        .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
        .s_wstrb(4'hf), .s_wvalid(s_wvalid), .s_wready(s_wready),
        .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
        .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
        .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
        .s_rready(s_rready), .flash_addr(f_addr), .flash_dq_o(dq_o),
        .flash_dq_oe(dq_oe), .flash_dq_i(dq_i), .chip_select_0_n(cs0_n),
        .chip_select_1_n(cs1_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
        .flash_byte_n(byte_n), .ready_busy_out(rb));
    fcsd_flash_model #(.MAKER_ID(MID), .PART_ID(PID)) u_flash (
        .addr(f_addr), .dq_o(dq_o), .cs0_n(cs0_n), .cs1_n(cs1_n),
        .oe_n(oe_n), .we_n(we_n), .byte_n(byte_n), .fail_en(fail_en),
        .dq_i(dq_i), .rb(rb));
    // ====
    // bus and check tasks
    task print_verdict;
        begin
            $display("checks %0d mismatches %0d", n_tests, fails);
            if (fails == 0 && n_tests > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            fails = fails + 1;
            print_verdict;
        end
    end
    task chk(input [15:0] got, input [15:0] exp);
        begin
            n_tests = n_tests + 1;
            if (got !== exp) begin
                fails = fails + 1;
                $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task axi_wr(input [7:0] a, input [31:0] d);
        begin
            s_awaddr <= a;
            s_wdata <= d;
            s_awvalid <= 1'b1;
            s_wvalid <= 1'b1;
            do begin
                @(posedge clk);
                if (s_awready) s_awvalid <= 1'b0;
                if (s_wready) s_wvalid <= 1'b0;
            end while ((s_awvalid && !s_awready) || (s_wvalid && !s_wready));
            do @(posedge clk); while (s_bvalid !== 1'b1);
            bs = s_bresp;
        end
    endtask
    task axi_rd(input [7:0] a);
        begin
            s_araddr <= a;
            s_arvalid <= 1'b1;
            do @(posedge clk); while (s_arready !== 1'b1);
            s_arvalid <= 1'b0;
            do @(posedge clk); while (s_rvalid !== 1'b1);
            r = s_rdata;
            rs = s_rresp;
        end
    endtask
    task run(input [13:0] c, input [20:0] a, input [15:0] d);
        begin
            axi_wr(`FCSD_REG_ADDR, {11'h0, a});
            axi_wr(`FCSD_REG_DATA1, {16'h0, d});
            axi_wr(`FCSD_REG_CTRL, {18'h0, c});
            do axi_rd(`FCSD_REG_STATUS); while (r[0] !== 1'b0);
            axi_rd(`FCSD_REG_RDATA);
        end
    endtask
    // ====
    // scenarios
    task t_bus;
        begin
            axi_rd(8'h20);
            chk({14'h0, rs}, {14'h0, `FCSD_RESP_ERR});
            axi_wr(8'h20, 32'h0);
            chk({14'h0, bs}, {14'h0, `FCSD_RESP_ERR});
            axi_wr(`FCSD_REG_ADDR, 32'h001abcde);
            chk({14'h0, bs}, {14'h0, `FCSD_RESP_OK});
            axi_rd(`FCSD_REG_ADDR);
            chk(r[15:0], 16'hbcde);
        end
    endtask
    task t_read;
        begin
            run(FR | 14'h00ff, 21'h01234, 16'h0000);
            chk(r[15:0], 16'h1234 ^ 16'h5555);
            run(FR | FB | 14'h0090, 21'h0, 16'h0000);
            chk({8'h0, r[7:0]}, {8'h0, MID[7:0]});
            run(FR | FB | 14'h0090, 21'h1, 16'h0000);
            chk({8'h0, r[7:0]}, {8'h0, PID[7:0]});
            run(FR | 14'h0090, 21'h2, 16'h0000);
            chk(r[15:0], PID);
            run(14'h0072, 21'h0, 16'h0000);
            run(FR | 14'h0075, 21'h00123, 16'h0000);
            chk(r[15:0], 16'h0123 ^ 16'h8aaa);
            run(FR | 14'h0071, 21'h00002, 16'h0000);
            chk(r[15:0], 16'h0002 ^ 16'h8aaa);
        end
    endtask
    task t_fail;
        begin
            run(F2 | FW | FR | 14'h0040, 21'h100, 16'habcd);
            chk({8'h0, r[7:0]}, 16'h0080);
            fail_en = 1'b1;
            run(F2 | FW | FR | 14'h0040, 21'h100, 16'habcd);
            chk({8'h0, r[7:0]}, 16'h0090);
            run(F2 | FW | FR | 14'h0020, 21'h0, 16'h00d0);
            chk({8'h0, r[7:0]}, 16'h00b0);
            axi_rd(`FCSD_REG_STATUS);
            chk({15'h0, r[2]}, 16'h0001);
            fail_en = 1'b0;
            run(14'h0050, 21'h0, 16'h0000);
            run(FR | 14'h0070, 21'h0, 16'h0000);
            chk({8'h0, r[7:0]}, 16'h0080);
            axi_rd(`FCSD_REG_STATUS);
            chk({15'h0, r[2]}, 16'h0000);
        end
    endtask
    task t_susp;
        begin
            run(F2 | 14'h0020, 21'h0, 16'h00d0);
            run(F2 | FR | 14'h00b0, 21'h0, 16'h00d0);
            chk({8'h0, r[7:0]}, 16'h00c0);
            run(F2 | FW | FR | 14'h00b0, 21'h0, 16'h00d0);
            chk({8'h0, r[7:0]}, 16'h0080);
        end
    endtask
    initial begin
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        do axi_rd(`FCSD_REG_STATUS); while (r[1] !== 1'b1);
        t_bus;
        t_read;
        t_fail;
        t_susp;
        print_verdict;
    end
endmodule // testbench
